// >>> logic/flow_ctrl_pkg.sv
// Shared constants, lane word kinds and code decoding for the stream port and rate control
package flow_ctrl_pkg;

  localparam int            CODE_W           = 4;
  localparam int            COUNT_W          = 9;
  localparam int            MIN_DATA_BYTES   = 2;
  localparam logic [3:0]    RESUME_CODE      = 4'h0;
  localparam logic [3:0]    LAST_FINITE_CODE = 4'h8;
  localparam logic [3:0]    STOP_CODE        = 4'hF;
  localparam logic [8:0]    COUNT_RST        = 9'h000;
  localparam logic [8:0]    COUNT_ONE        = 9'h001;

  // What the lane carries in one beat
  typedef enum logic [3:0] {
    KIND_IDLE = 4'h1,
    KIND_DATA = 4'h2,
    KIND_COMP = 4'h4,
    KIND_RATE = 4'h8
  } lane_kind_type;

  function automatic logic is_reserved(input logic [3:0] code);
    return (code > LAST_FINITE_CODE) && (code != STOP_CODE);
  endfunction

  // Codes 1..8 ask for 2**code idle beats
  function automatic logic [8:0] idle_beats(input logic [3:0] code);
    return COUNT_ONE << code;
  endfunction

endpackage

// >>> logic/idle_ctrl_if.sv
// Control path between the transmit scheduler and the idle beat counter
`timescale 1ns/10ps
interface idle_ctrl_if;
  logic       load;
  logic [3:0] code;
  logic       beat;
  logic       busy;
  logic       last_beat;

  modport ctrl (output load, output code, output beat, input busy, input last_beat);
  modport cnt  (input load, input code, input beat, output busy, output last_beat);
endinterface

// >>> logic/idle_beat_counter.sv
// Counts idle beats still owed to the partner after a received rate request
`timescale 1ns/10ps
module idle_beat_counter (
  input  wire logic  ref_clk,  // System clock
  input  wire logic  arst_n,   // Asynchronous reset, active low
  idle_ctrl_if.cnt   ic        // Load, beat and busy
);

  logic [8:0] count_ff;
  logic [8:0] nxt_count;
  logic       forever_ff;
  logic       nxt_forever;

  always_comb begin
    nxt_count   = count_ff;
    nxt_forever = forever_ff;
    if (ic.load) begin
      if (ic.code == flow_ctrl_pkg::RESUME_CODE) begin
        nxt_count   = flow_ctrl_pkg::COUNT_RST;
        nxt_forever = 1'b0;
      end else if (ic.code == flow_ctrl_pkg::STOP_CODE) begin
        nxt_count   = flow_ctrl_pkg::COUNT_RST;
        nxt_forever = 1'b1;
      end else if (!flow_ctrl_pkg::is_reserved(ic.code)) begin
        nxt_count   = flow_ctrl_pkg::idle_beats(ic.code);
        nxt_forever = 1'b0;
      end
    end else if (ic.beat && count_ff != flow_ctrl_pkg::COUNT_RST) begin
      nxt_count = count_ff - flow_ctrl_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff   <= flow_ctrl_pkg::COUNT_RST;
      forever_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      forever_ff <= nxt_forever;
    end
  end

  assign ic.busy      = forever_ff || (count_ff != flow_ctrl_pkg::COUNT_RST);
  assign ic.last_beat = !forever_ff && (count_ff == flow_ctrl_pkg::COUNT_ONE) && ic.beat;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_resume_clears: assert property (ic.load && ic.code == flow_ctrl_pkg::RESUME_CODE |=> !ic.busy)
    else $error("resume code did not clear the idle debt");
  chk_stop_forever: assert property (ic.load && ic.code == flow_ctrl_pkg::STOP_CODE |=> ic.busy [*8])
    else $error("stop code did not hold the transmitter");
  chk_count_load: assert property (ic.load && ic.code != flow_ctrl_pkg::RESUME_CODE
      && ic.code <= flow_ctrl_pkg::LAST_FINITE_CODE
      |=> count_ff == (flow_ctrl_pkg::COUNT_ONE << $past(ic.code)))
    else $error("idle count loaded with wrong beat number");

endmodule

// >>> logic/stream_port_native_flow_ctrl.sv
// Stream port datapath with rate control request, grant and idle insertion
// Summary of operation
// - Ready after channel up, except clock compensation
// - Word moves only when valid and ready
// - Ready stays high unless channel cannot take
// - Accepted words reach receiver in order
// - User gaps reproduced, except near compensation
// - Four-bit codes: resume, 2..256 beats, reserved
// - Stop code makes partner send only idles
// - Code is minimum idles partner must insert
// - No data while sending; ready low after grant
// - One message costs one ready-low cycle
// - Received request keeps ready low until satisfied
// - Immediate inserts now; completion waits frame end
// - Rate control only in framing configuration
`timescale 1ns/10ps
module stream_port_native_flow_ctrl #(
  parameter int DATA_BYTES = 4  // Width of the user data word in bytes
) (
  input  wire logic                        ref_clk,            // System clock
  input  wire logic                        arst_n,             // Async reset, active low
  input  wire logic                        channel_up,         // Channel initialized
  input  wire logic                        framing_mode,       // Framing configuration
  input  wire logic                        immediate_mode,     // Immediate idle insertion
  input  wire logic                        clock_comp_request, // Compensation beat due
  input  wire logic [8*DATA_BYTES-1:0]     tx_data,            // User transmit word
  input  wire logic                        tx_valid,           // User word valid
  input  wire logic                        tx_last,            // Last word of frame
  output logic                             tx_ready,           // Core takes word
  input  wire logic                        idle_req_strobe,    // Rate message request
  input  wire logic [3:0]                  idle_req_code,      // Rate message code
  output logic                             idle_req_grant,     // Request taken, one cycle
  output flow_ctrl_pkg::lane_kind_type     lane_tx_kind,       // Kind of lane beat
  output logic [8*DATA_BYTES-1:0]          lane_tx_data,       // Lane beat data
  output logic                             lane_tx_last,       // Lane beat ends frame
  output logic [3:0]                       lane_tx_code,       // Code sent in rate beat
  input  wire logic                        lane_rx_valid,      // Lane received word
  input  wire logic [8*DATA_BYTES-1:0]     lane_rx_data,       // Lane received data
  input  wire logic                        lane_rx_last,       // Lane received frame end
  input  wire logic                        lane_rx_code_valid, // Partner rate message
  input  wire logic [3:0]                  lane_rx_code,       // Partner rate code
  output logic                             rx_valid,           // User receive valid
  output logic [8*DATA_BYTES-1:0]          rx_data,            // User receive word
  output logic                             rx_last             // User receive frame end
);

  localparam int DW = 8 * DATA_BYTES;

  // A one-byte word would need two ready-low cycles per rate message
  if (DATA_BYTES < flow_ctrl_pkg::MIN_DATA_BYTES) begin : g_width_check
    $error("DATA_BYTES below the smallest supported width");
  end

  idle_ctrl_if ic ();

  idle_beat_counter u_idle_cnt (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .ic      (ic)
  );

  logic                         tx_ready_ff;
  logic                         nxt_tx_ready;
  logic                         grant_ff;
  logic                         nxt_grant;
  logic                         rate_pend_ff;
  logic                         nxt_rate_pend;
  logic [3:0]                   rate_code_ff;
  logic [3:0]                   nxt_rate_code;
  logic                         comp_pend_ff;
  logic                         nxt_comp_pend;
  logic                         in_frame_ff;
  logic                         nxt_in_frame;
  logic                         deferred_ff;
  logic                         nxt_deferred;
  logic [3:0]                   deferred_code_ff;
  logic [3:0]                   nxt_deferred_code;
  flow_ctrl_pkg::lane_kind_type lane_kind_ff;
  flow_ctrl_pkg::lane_kind_type nxt_lane_kind;
  logic [DW-1:0]                lane_data_ff;
  logic [DW-1:0]                nxt_lane_data;
  logic                         lane_last_ff;
  logic                         nxt_lane_last;
  logic [3:0]                   lane_code_ff;
  logic [3:0]                   nxt_lane_code;
  logic                         rx_valid_ff;
  logic [DW-1:0]                rx_data_ff;
  logic                         rx_last_ff;

  logic accept;
  logic rate_ok;
  logic comp_now;
  logic rx_now;
  logic def_fire;
  logic hold_next;

  assign accept   = tx_valid && tx_ready_ff;
  assign rate_ok  = framing_mode && channel_up;
  assign comp_now = (clock_comp_request || comp_pend_ff) && !accept;

  // Resume bypasses completion deferral so a stop never outlives it
  assign rx_now   = rate_ok && lane_rx_code_valid
                    && (immediate_mode || !in_frame_ff
                        || lane_rx_code == flow_ctrl_pkg::RESUME_CODE);
  assign def_fire = deferred_ff && !in_frame_ff && !rx_now;

  assign ic.load  = rx_now || def_fire;
  assign ic.code  = rx_now ? lane_rx_code : deferred_code_ff;
  assign ic.beat  = (nxt_lane_kind == flow_ctrl_pkg::KIND_IDLE) && ic.busy;

  // Request side: grant is one pulse, message goes out in a ready-low cycle
  always_comb begin
    nxt_grant     = rate_ok && idle_req_strobe && !grant_ff && !rate_pend_ff;
    nxt_rate_pend = rate_pend_ff;
    nxt_rate_code = rate_code_ff;
    if (grant_ff) begin
      nxt_rate_pend = 1'b1;
      nxt_rate_code = idle_req_code;
    end else if (nxt_lane_kind == flow_ctrl_pkg::KIND_RATE) begin
      nxt_rate_pend = 1'b0;
    end
    nxt_comp_pend = clock_comp_request && accept;
  end

  // Frame tracking and completion-mode deferral
  always_comb begin
    nxt_in_frame      = accept ? (framing_mode && !tx_last) : in_frame_ff;
    nxt_deferred      = deferred_ff;
    nxt_deferred_code = deferred_code_ff;
    if (rx_now) begin
      nxt_deferred = 1'b0;
    end else if (rate_ok && lane_rx_code_valid) begin
      nxt_deferred      = 1'b1;
      nxt_deferred_code = lane_rx_code;
    end else if (def_fire) begin
      nxt_deferred = 1'b0;
    end
  end

  // Lane beat selection: accepted data first, then compensation, then message
  always_comb begin
    nxt_lane_kind = flow_ctrl_pkg::KIND_IDLE;
    nxt_lane_data = '0;
    nxt_lane_last = 1'b0;
    nxt_lane_code = flow_ctrl_pkg::RESUME_CODE;
    if (accept) begin
      nxt_lane_kind = flow_ctrl_pkg::KIND_DATA;
      nxt_lane_data = tx_data;
      nxt_lane_last = framing_mode && tx_last;
    end else if (comp_now) begin
      nxt_lane_kind = flow_ctrl_pkg::KIND_COMP;
    end else if (rate_pend_ff) begin
      nxt_lane_kind = flow_ctrl_pkg::KIND_RATE;
      nxt_lane_code = rate_code_ff;
    end
  end

  // Ready decided a cycle ahead so the port comes from a flop
  always_comb begin
    if (ic.load) begin
      hold_next = flow_ctrl_pkg::is_reserved(ic.code) ? ic.busy
                : (ic.code != flow_ctrl_pkg::RESUME_CODE);
    end else begin
      hold_next = ic.busy && !ic.last_beat;
    end
    nxt_tx_ready = channel_up && !clock_comp_request && !nxt_comp_pend
                   && !grant_ff && !nxt_rate_pend && !hold_next;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready_ff      <= 1'b0;
      grant_ff         <= 1'b0;
      rate_pend_ff     <= 1'b0;
      rate_code_ff     <= flow_ctrl_pkg::RESUME_CODE;
      comp_pend_ff     <= 1'b0;
      in_frame_ff      <= 1'b0;
      deferred_ff      <= 1'b0;
      deferred_code_ff <= flow_ctrl_pkg::RESUME_CODE;
      lane_kind_ff     <= flow_ctrl_pkg::KIND_IDLE;
      lane_data_ff     <= '0;
      lane_last_ff     <= 1'b0;
      lane_code_ff     <= flow_ctrl_pkg::RESUME_CODE;
    end else begin
      tx_ready_ff      <= nxt_tx_ready;
      grant_ff         <= nxt_grant;
      rate_pend_ff     <= nxt_rate_pend;
      rate_code_ff     <= nxt_rate_code;
      comp_pend_ff     <= nxt_comp_pend;
      in_frame_ff      <= nxt_in_frame;
      deferred_ff      <= nxt_deferred;
      deferred_code_ff <= nxt_deferred_code;
      lane_kind_ff     <= nxt_lane_kind;
      lane_data_ff     <= nxt_lane_data;
      lane_last_ff     <= nxt_lane_last;
      lane_code_ff     <= nxt_lane_code;
    end
  end

  // Receive has no back-pressure: one register stage and no holding
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
      rx_last_ff  <= 1'b0;
    end else begin
      rx_valid_ff <= lane_rx_valid;
      rx_data_ff  <= lane_rx_data;
      rx_last_ff  <= lane_rx_valid && lane_rx_last && framing_mode;
    end
  end

  assign tx_ready       = tx_ready_ff;
  assign idle_req_grant = grant_ff;
  assign lane_tx_kind   = lane_kind_ff;
  assign lane_tx_data   = lane_data_ff;
  assign lane_tx_last   = lane_last_ff;
  assign lane_tx_code   = lane_code_ff;
  assign rx_valid       = rx_valid_ff;
  assign rx_data        = rx_data_ff;
  assign rx_last        = rx_last_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence grant_then_clear;
    idle_req_grant ##1 (!clock_comp_request && !comp_pend_ff);
  endsequence

  chk_ready_after_grant: assert property (idle_req_grant |=> !tx_ready)
    else $error("ready high in the cycle after a grant");
  chk_message_sent: assert property (grant_then_clear |=> lane_tx_kind == flow_ctrl_pkg::KIND_RATE
      && lane_tx_code == $past(idle_req_code, 2))
    else $error("rate message not sent with the granted code");
  chk_data_order: assert property (tx_valid && tx_ready |=> lane_tx_kind == flow_ctrl_pkg::KIND_DATA
      && lane_tx_data == $past(tx_data))
    else $error("accepted word not forwarded next cycle");
  chk_gap_kept: assert property (!tx_valid && !clock_comp_request && !comp_pend_ff
      |=> lane_tx_kind != flow_ctrl_pkg::KIND_DATA)
    else $error("user gap filled with data");
  chk_comp_blocks: assert property (clock_comp_request |=> !tx_ready)
    else $error("ready high during compensation");
  chk_rx_passes: assert property (lane_rx_valid |=> rx_valid && rx_data == $past(lane_rx_data))
    else $error("received word not presented");
  chk_hold_ready: assert property (ic.busy && !ic.load && !ic.last_beat |=> !tx_ready)
    else $error("ready high while idles still owed");
  chk_streaming_plain: assert property (!framing_mode |=> !idle_req_grant)
    else $error("grant issued in streaming configuration");
  chk_completion_wait: assert property (!immediate_mode && in_frame_ff && lane_rx_code_valid
      && framing_mode && channel_up && lane_rx_code != flow_ctrl_pkg::RESUME_CODE
      |-> !ic.load || deferred_ff)
    else $error("completion mode loaded idles mid-frame");

  // A finite or stop code must take ready down on the next cycle
  sequence debt_arrives;
    rate_ok && lane_rx_code_valid && immediate_mode
    && lane_rx_code != flow_ctrl_pkg::RESUME_CODE
    && !flow_ctrl_pkg::is_reserved(lane_rx_code);
  endsequence

  // Resume acts even inside a frame, so no deferral term here
  sequence resume_arrives;
    rate_ok && lane_rx_code_valid && lane_rx_code == flow_ctrl_pkg::RESUME_CODE;
  endsequence

  sequence data_then_comp;
    lane_tx_kind == flow_ctrl_pkg::KIND_DATA ##1 lane_tx_kind == flow_ctrl_pkg::KIND_COMP;
  endsequence

  chk_debt_stalls: assert property (debt_arrives |=> !tx_ready)
    else $error("ready high after a received idle request");
  chk_resume_frees: assert property (resume_arrives ##0 (!clock_comp_request && !grant_ff
      && !rate_pend_ff) |=> tx_ready)
    else $error("ready still low after a resume code");

  chk_channel_down: assert property (!channel_up |=> !tx_ready)
    else $error("ready high before the channel is up");
  chk_no_data_stall: assert property (!tx_ready
      |=> lane_tx_kind != flow_ctrl_pkg::KIND_DATA)
    else $error("data beat sent without a ready cycle");
  chk_grant_pulse: assert property (idle_req_grant |=> !idle_req_grant)
    else $error("grant held longer than one cycle");
  chk_grant_cause: assert property (idle_req_grant
      |-> $past(idle_req_strobe) && $past(rate_ok))
    else $error("grant without a request in framing configuration");

  // Data wins the cycle; the compensation beat follows right behind it
  chk_comp_beat: assert property (clock_comp_request && !accept
      |=> lane_tx_kind == flow_ctrl_pkg::KIND_COMP)
    else $error("compensation beat not sent");
  chk_comp_after_data: assert property (clock_comp_request && accept |=> data_then_comp)
    else $error("compensation beat lost behind accepted data");

  chk_last_kept: assert property (accept && tx_last && framing_mode |=> lane_tx_last)
    else $error("frame end not forwarded to the lane");
  chk_rx_last: assert property (lane_rx_valid && lane_rx_last && framing_mode
      |=> rx_last)
    else $error("received frame end not presented");
  chk_rx_last_plain: assert property (!framing_mode |=> !rx_last)
    else $error("frame end shown in streaming configuration");

endmodule

// >>> tb/lane_partner.sv
// Remote channel partner: returns lane beats as received words and sends rate codes
`timescale 1ns/10ps
module lane_partner (
  input  wire logic                         ref_clk,    // System clock
  input  wire logic                         arst_n,     // Async reset, active low
  input  wire flow_ctrl_pkg::lane_kind_type tx_kind,    // Beat kind from core
  input  wire logic [31:0]                  tx_data,    // Beat data from core
  input  wire logic                         tx_last,    // Beat ends frame
  input  wire logic                         inj,        // Send one rate code
  input  wire logic [3:0]                   inj_code,   // Code to send
  output logic                              rx_valid,   // Word to core
  output logic [31:0]                       rx_data,    // Word data to core
  output logic                              rx_last,    // Word ends frame
  output logic                              code_valid, // Rate message to core
  output logic [3:0]                        code        // Rate code to core
);
  logic is_data;
  assign is_data = (tx_kind == flow_ctrl_pkg::KIND_DATA);
  // Lines not carrying a word show the inverse, so stale data never passes for new
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid   <= 1'b0;
      rx_data    <= 32'h0;
      rx_last    <= 1'b0;
      code_valid <= 1'b0;
      code       <= 4'h0;
    end else begin
      rx_valid   <= is_data;
      rx_data    <= is_data ? tx_data : ~rx_data;
      rx_last    <= is_data ? tx_last : ~rx_last;
      code_valid <= inj;
      code       <= inj ? inj_code : ~code;
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the stream port and rate control
`timescale 1ns/10ps
module testbench;
  logic                         ref_clk = 1'b0;
  logic                         arst_n = 1'b0;
  logic                         channel_up = 1'b0;
  logic                         framing_mode = 1'b0;
  logic                         immediate_mode = 1'b1;
  logic                         comp_req = 1'b0;
  logic [31:0]                  tx_data = 32'h0;
  logic                         tx_valid = 1'b0;
  logic                         tx_last = 1'b0;
  logic                         strobe = 1'b0;
  logic [3:0]                   req_code = 4'h0;
  logic                         inj = 1'b0;
  logic [3:0]                   inj_code = 4'h0;
  logic                         rnd_on = 1'b0;
  logic                         tx_ready, grant, l_last, lr_valid, lr_last, lr_cv;
  logic                         rx_valid, rx_last;
  logic [31:0]                  l_data, lr_data, rx_data;
  logic [3:0]                   l_code, lr_code;
  flow_ctrl_pkg::lane_kind_type kind;
  logic [2:0]                   hist = 3'h0;
  logic [32:0]                  exp_q[$];
  int                           n_errors = 0;
  int                           checked = 0;
  int                           cycles = 0;
  int                           lows;

  always #5 ref_clk = ~ref_clk;

  stream_port_native_flow_ctrl #(.DATA_BYTES(4)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .channel_up(channel_up), .framing_mode(framing_mode), .immediate_mode(immediate_mode),
    .clock_comp_request(comp_req), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .idle_req_strobe(strobe), .idle_req_code(req_code),
    .idle_req_grant(grant), .lane_tx_kind(kind), .lane_tx_data(l_data), .lane_tx_last(l_last),
    .lane_tx_code(l_code), .lane_rx_valid(lr_valid), .lane_rx_data(lr_data),
    .lane_rx_last(lr_last), .lane_rx_code_valid(lr_cv), .lane_rx_code(lr_code),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

  lane_partner lp (.ref_clk(ref_clk), .arst_n(arst_n), .tx_kind(kind), .tx_data(l_data),
    .tx_last(l_last), .inj(inj), .inj_code(inj_code), .rx_valid(lr_valid), .rx_data(lr_data),
    .rx_last(lr_last), .code_valid(lr_cv), .code(lr_code));

  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    checked++;
    if (seen !== expd) begin
      n_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Pipe model: every taken word comes out three edges later, in order, gaps kept
  always @(posedge ref_clk) begin
    if (!arst_n) begin
      hist = 3'h0;
    end else begin
      check(rx_valid, hist[2]);
      if (rx_valid === 1'b1 && exp_q.size() > 0) begin
        check({rx_last, rx_data}, exp_q.pop_front());
      end
      hist = {hist[1:0], tx_valid & tx_ready};
      if ((tx_valid & tx_ready) === 1'b1) exp_q.push_back({tx_last & framing_mode, tx_data});
    end
  end

  // Random user traffic that holds a word until it is taken
  always @(posedge ref_clk) begin
    if (rnd_on && !(tx_valid && !tx_ready)) begin
      tx_valid <= 1'($urandom % 2);
      tx_data  <= $urandom;
      tx_last  <= ($urandom % 4) == 0;
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic inject(input logic [3:0] c, input int win, output int lo);
    @(posedge ref_clk) begin inj <= 1'b1; inj_code <= c; end
    @(posedge ref_clk) inj <= 1'b0;
    lo = 0;
    repeat (win) begin @(negedge ref_clk); if (tx_ready === 1'b0) lo++; end
  endtask

  task automatic send_req(input logic [3:0] c, input logic want);
    int n;
    @(posedge ref_clk) begin strobe <= 1'b1; req_code <= c; end
    n = 0;
    do begin @(negedge ref_clk); n++; end while (grant !== 1'b1 && n < 20);
    check(grant, want);
    @(posedge ref_clk) strobe <= 1'b0;
    if (want) begin
      @(negedge ref_clk);
      check(tx_ready, 0);
      @(negedge ref_clk);
      check({kind, l_code}, {flow_ctrl_pkg::KIND_RATE, c});
      check(tx_ready, 1);
    end
  endtask

  initial begin
    void'($urandom(27));
    repeat (3) @(posedge ref_clk);
    check({tx_ready, kind}, {1'b0, flow_ctrl_pkg::KIND_IDLE});
    arst_n <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check(tx_ready, 0);
    @(posedge ref_clk) channel_up <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check(tx_ready, 1);
    $display("test reset done");
    @(posedge ref_clk) rnd_on <= 1'b1;
    repeat (300) @(posedge ref_clk) comp_req <= ($urandom % 23) == 0;
    @(posedge ref_clk) begin rnd_on <= 1'b0; comp_req <= 1'b0; end
    @(posedge ref_clk) tx_valid <= 1'b0;
    repeat (5) @(posedge ref_clk);
    $display("test stream done");
    @(posedge ref_clk) comp_req <= 1'b1;
    @(posedge ref_clk) comp_req <= 1'b0;
    @(negedge ref_clk) check(tx_ready, 0);
    repeat (3) @(negedge ref_clk);
    check(tx_ready, 1);
    $display("test compensation done");
    send_req(4'h3, 1'b0);
    @(posedge ref_clk) framing_mode <= 1'b1;
    for (int i = 0; i < 10; i++) send_req((i < 9) ? 4'(i) : 4'hF, 1'b1);
    $display("test send done");
    for (int k = 1; k <= 8; k++) begin
      inject(4'(k), (1 << k) + 6, lows);
      check(lows, 1 << k);
    end
    for (int c = 9; c <= 14; c++) begin
      inject(4'(c), 4, lows);
      check(lows, 0);
    end
    inject(4'hF, 40, lows);
    check(lows, 39);
    inject(4'h0, 6, lows);
    check(lows, 1);
    $display("test receive done");
    @(posedge ref_clk) begin immediate_mode <= 1'b0; tx_valid <= 1'b1; tx_data <= $urandom; end
    inject(4'h1, 6, lows);
    check(lows, 0);
    @(posedge ref_clk) tx_last <= 1'b1;
    @(posedge ref_clk) begin tx_valid <= 1'b0; tx_last <= 1'b0; end
    lows = 0;
    repeat (6) begin @(negedge ref_clk); if (tx_ready === 1'b0) lows++; end
    check(lows, 2);
    @(posedge ref_clk) begin immediate_mode <= 1'b1; tx_valid <= 1'b1; end
    inject(4'h1, 6, lows);
    check(lows, 2);
    @(posedge ref_clk) tx_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
    $display("test completion done");
    wrap_up();
  end
endmodule
